/* hdl/rbm_pkg.sv */
// Constants shared by the reset and boot mode control block.
// Assumes a single processor clock and no software-visible registers.
// Operation
// R1 - External reset resets processor and peripherals immediately.
// R2 - Reset indication stays low 512 clocks after release.
// R3 - Config asserted, test negated at exit: flash programming.
// R4 - Programming mode grants serial flash port flash access.
// R5 - Clock mirror pin copies the system clock.
// R6 - Board holds test pin low in normal use.
// R7 - Reset indication low while any reset source asserted.
package rbm_pkg;
  localparam int          STRETCH_CYCLES = 512;
  localparam int          CNT_W          = 10;
  localparam logic [9:0]  CNT_RESET      = 10'h000;
  localparam logic        DONE_RESET     = 1'b0;
  localparam logic        MODE_RESET     = 1'b0;
  localparam logic        TAKEN_RESET    = 1'b0;
endpackage : rbm_pkg

/* hdl/rbm_reset_boot.sv */
// Chip reset and boot mode control: reset fan-out, stretched reset
// indication, boot mode sampling at reset exit and the clock mirror pin.
// Assumes all pin inputs are synchronous to clk_sys and that reset_n is
// the power-on reset of the chip.
module rbm_reset_boot #(
  parameter int STRETCH = rbm_pkg::STRETCH_CYCLES
) (
  // Clock and power-on reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Reset sources
  input  wire logic external_reset_input_n,
  input  wire logic internal_reset_req,
  // Boot mode pins
  input  wire logic boot_config_pin_n,
  input  wire logic test_pin,
  // Reset outputs
  output logic      core_reset_n,
  output logic      reset_indication_output_n,
  // Boot mode results
  output logic      flash_prog_mode,
  output logic      serial_flash_port_grant,
  output logic      cpu_boot_enable,
  // Clock mirror
  output logic      system_clock_mirror
);
  // The quiet field counts cycles since the last reset source, saturating;
  // only the checks read it.
  typedef struct packed {
    logic        prog_mode;
    logic        taken;
    logic [10:0] quiet;
  } rbm_mode_s;

  rbm_mode_s st;
  rbm_mode_s next_st;
  logic      src_active;
  logic      stretch_done;

  // The stretch counter is ten bits wide, so stretches above 1000 are refused.
  if (STRETCH < 1 || STRETCH > 1000) begin : g_bad_stretch
    $error("rbm_reset_boot: STRETCH out of the supported range");
  end

  // The external input acts without any clock so the core is held even
  // when the clock is not yet running.
  assign src_active   = !reset_n || !external_reset_input_n || internal_reset_req;
  assign core_reset_n = !src_active; // [R1]

  rbm_stretch #(
    .STRETCH (STRETCH),
    .WIDTH   (rbm_pkg::CNT_W)
  ) u_stretch (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .src_active (src_active),
    .done       (stretch_done)
  );

  // Gating with the live source level makes the pin fall in the same cycle
  // as the source, at the cost of a short combinational path to the pin.
  assign reset_indication_output_n = stretch_done && !src_active; // [R2] [R7]

  // The mode is taken on the first clock with no source active, so a
  // programmer sees a stable mode for the whole stretch interval.
  always_comb begin
    next_st = st;
    if (src_active) begin
      next_st.taken     = 1'b0;
      next_st.prog_mode = rbm_pkg::MODE_RESET;
    end else if (!st.taken) begin
      next_st.taken     = 1'b1;
      next_st.prog_mode = !boot_config_pin_n && !test_pin; // [R3] [R6]
    end
    if (src_active) begin
      next_st.quiet = 11'h000;
    end else if (st.quiet != 11'h7FF) begin
      next_st.quiet = st.quiet + 11'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st.prog_mode <= rbm_pkg::MODE_RESET;
      st.taken     <= rbm_pkg::TAKEN_RESET;
      st.quiet     <= 11'h000;
    end else begin
      st <= next_st;
    end
  end

  assign flash_prog_mode         = st.prog_mode;
  assign serial_flash_port_grant = st.taken && st.prog_mode; // [R4]
  assign cpu_boot_enable         = st.taken && !st.prog_mode && stretch_done;

  // The clock pin is a plain copy; any pad delay lies outside this block.
  assign system_clock_mirror = clk_sys; // [R5]

  core_reset_now_a : assert property (@(posedge clk_sys) // [R1]
    !external_reset_input_n |-> !core_reset_n)
    else $error("core not in reset with external reset low");

  boot_held_a : assert property (@(posedge clk_sys) disable iff (!reset_n) // [R1]
    src_active |=> (!cpu_boot_enable && !serial_flash_port_grant))
    else $error("boot or flash grant kept during reset");

  release_exact_a : assert property (@(posedge clk_sys) disable iff (!reset_n) // [R2]
    $rose(reset_indication_output_n) |-> (st.quiet == 11'(STRETCH)))
    else $error("indication released at wrong count");

  release_held_a : assert property (@(posedge clk_sys) disable iff (!reset_n) // [R2]
    (st.quiet < 11'(STRETCH)) |-> !reset_indication_output_n)
    else $error("indication released early");

  release_late_a : assert property (@(posedge clk_sys) disable iff (!reset_n) // [R2]
    (st.quiet == 11'(STRETCH)) && !src_active |-> reset_indication_output_n)
    else $error("indication not released after stretch");

  mode_sample_a : assert property (@(posedge clk_sys) disable iff (!reset_n) // [R3]
    $rose(st.taken) |-> (flash_prog_mode == ($past(!boot_config_pin_n) && !$past(test_pin))))
    else $error("boot mode sampled wrongly");

  mode_stable_a : assert property (@(posedge clk_sys) disable iff (!reset_n) // [R3]
    st.taken && !src_active |=> $stable(flash_prog_mode))
    else $error("boot mode changed outside reset");

  flash_grant_a : assert property (@(posedge clk_sys) disable iff (!reset_n) // [R4]
    serial_flash_port_grant |-> (flash_prog_mode && !cpu_boot_enable))
    else $error("flash port grant in wrong mode");

  // Sampled values lag the clock edge, so the mirror reads low at the rising
  // edge and high at the falling edge when it truly follows the clock.
  clock_mirror_a : assert property (@(negedge clk_sys) // [R5]
    system_clock_mirror)
    else $error("clock mirror low while clock high");

  mirror_low_a : assert property (@(posedge clk_sys) // [R5]
    !system_clock_mirror)
    else $error("clock mirror high while clock low");

  source_low_a : assert property (@(posedge clk_sys) // [R7]
    (internal_reset_req || !external_reset_input_n) |-> (!reset_indication_output_n && !core_reset_n))
    else $error("indication high while source active");
endmodule : rbm_reset_boot

/* hdl/rbm_stretch.sv */
// Release stretcher: counts processor clocks with no reset source active.
// Assumes the source level is synchronous to clk_sys.
module rbm_stretch #(
  parameter int STRETCH = rbm_pkg::STRETCH_CYCLES,
  parameter int WIDTH   = rbm_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Reset source level and result
  input  wire logic src_active,
  output logic      done
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             done;
  } rbm_stretch_s;

  rbm_stretch_s st;
  rbm_stretch_s next_st;

  // A stretch that does not fit the counter would be truncated to the counter width and end too early.
  if (STRETCH < 1 || STRETCH >= (1 << WIDTH)) begin : g_bad_stretch
    $error("rbm_stretch: STRETCH does not fit the counter width");
  end

  localparam logic [WIDTH-1:0] LAST = WIDTH'(STRETCH);

  always_comb begin
    next_st = st;
    if (src_active) begin
      next_st.count = '0; // [R7]
      next_st.done  = 1'b0; // [R7]
    end else begin
      if (st.count != LAST) begin
        next_st.count = st.count + WIDTH'(1); // [R2]
      end
      next_st.done = (next_st.count == LAST); // [R2]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st.count <= WIDTH'(rbm_pkg::CNT_RESET);
      st.done  <= rbm_pkg::DONE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;

  stretch_clear_a : assert property (@(posedge clk_sys) disable iff (!reset_n) // [R7]
    src_active |=> (!done && st.count == '0))
    else $error("stretch not cleared by reset source");
endmodule : rbm_stretch

/* sim/rbm_board_model.sv */
// Board side model: reset button, boot configuration strap and test strap.
// Assumes the bench changes its commands just after a rising edge of clk_sys.
module rbm_board_model (
  // Commands from the bench
  input  wire logic press_reset,
  input  wire logic strap_prog,
  input  wire logic strap_test,
  // Pins toward the device
  output logic      external_reset_input_n,
  output logic      boot_config_pin_n,
  output logic      test_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign external_reset_input_n = !press_reset;
  assign boot_config_pin_n      = !strap_prog;
  // Held low unless a scenario asks for the test strap on purpose.
  assign test_pin               = strap_test;
endmodule : rbm_board_model

/* sim/test_rbm_reset_boot.sv */
// Self-checking bench for the reset and boot mode control block.
// Assumes the board model drives the pins and a short stretch parameter.
module test_rbm_reset_boot;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 8;
  logic clk_sys = 1'b0, reset_n = 1'b0, hold = 1'b0, prog = 1'b0, tst = 1'b0, irq = 1'b0;
  logic ext_n, cfg_n, tpin, core_n, ind_n, fpm, grant, boot_en, mirror;
  int   error_cnt = 0, check_count = 0;
  always #5 clk_sys = ~clk_sys;
  rbm_board_model BRD (.press_reset(hold), .strap_prog(prog), .strap_test(tst),
    .external_reset_input_n(ext_n), .boot_config_pin_n(cfg_n), .test_pin(tpin));
  rbm_reset_boot #(.STRETCH(ST)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .external_reset_input_n(ext_n), .internal_reset_req(irq), .boot_config_pin_n(cfg_n),
    .test_pin(tpin), .core_reset_n(core_n), .reset_indication_output_n(ind_n),
    .flash_prog_mode(fpm), .serial_flash_port_grant(grant), .cpu_boot_enable(boot_en),
    .system_clock_mirror(mirror));
  task automatic check(string name, logic seen, logic exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", name, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // Called in the time step of the edge at which the last source was released.
  task automatic stretch_check(logic exp_prog);
    @(posedge clk_sys);
    #1;
    check("core_reset_n", core_n, 1'b1);
    check("flash_prog_mode", fpm, exp_prog);
    check("port_grant", grant, exp_prog);
    repeat (ST - 2) @(posedge clk_sys);
    #1 check("indication_late", ind_n, 1'b0);
    @(posedge clk_sys);
    #1 check("indication_done", ind_n, 1'b1);
    check("cpu_boot_enable", boot_en, !exp_prog);
  endtask : stretch_check
  // Board reset with the straps set; the straps are let go only after sampling.
  task automatic t_board_reset(logic p, logic t);
    @(posedge clk_sys);
    hold <= 1'b1;
    prog <= p;
    tst  <= t;
    #1 check("core_reset_n", core_n, 1'b0);
    check("indication", ind_n, 1'b0);
    repeat (3) @(posedge clk_sys);
    #1 check("indication_held", ind_n, 1'b0);
    @(posedge clk_sys);
    hold <= 1'b0;
    stretch_check(p && !t);
    @(posedge clk_sys);
    prog <= 1'b0;
    tst  <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check("mode_kept", fpm, p && !t);
  endtask : t_board_reset
  // A second source in mid-stretch restarts the whole count.
  task automatic t_restart();
    @(posedge clk_sys);
    irq <= 1'b1;
    @(posedge clk_sys);
    irq <= 1'b0;
    repeat (ST - 3) @(posedge clk_sys);
    irq <= 1'b1;
    #1 check("core_reset_n", core_n, 1'b0);
    check("indication", ind_n, 1'b0);
    @(posedge clk_sys);
    irq <= 1'b0;
    stretch_check(1'b0);
  endtask : t_restart
  task automatic t_mirror();
    @(posedge clk_sys);
    #1 check("mirror_high", mirror, 1'b1);
    #5 check("mirror_low", mirror, 1'b0);
  endtask : t_mirror
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    stretch_check(1'b0);
    t_board_reset(1'b1, 1'b0);
    t_board_reset(1'b1, 1'b1);
    t_board_reset(1'b0, 1'b0);
    t_restart();
    t_mirror();
    test_done();
  end
  initial begin
    #5000;
    error_cnt++;
    test_done();
  end
endmodule : test_rbm_reset_boot
